/* hw/rtcirq_top.sv */
// rtc interrupt, square-wave, oscillator gate and ram-clear logic behind wishbone
//
// Summary of operation
// - three maskable sources (periodic, alarm, update), one request
// - request low while enabled flag is set
// - reading status register clears request
// - reset input clears pending interrupt conditions while supply is good
// - request floats when nothing enabled pending
// - request is open-drain: pull low or float
// - ram clear sets general ram to ones
// - clear only on battery, input held low
// - square wave picks one of 13 taps
// - rate field in control a selects tap
// - square-wave enable bit in control b
// - no square wave below power-fail trip
// - host access blocked below power-fail trip
// - 14 clock bytes plus 114 ram bytes
// - 12 or 24 hour mode bit, am/pm
// - follow selected bus timing convention; bus_mode_i is not used, the port is wishbone classic only
// - divider chain runs from 32.768 khz timebase
// - oscillator field in control a starts and stops oscillator
// - reset clears enables, flags, square-wave enable while supply is good
// - bus refused while reset input low
// - status and supply registers read-only
//
// Added by the designer: the Wishbone interface to the registers and the address map.
`timescale 1ns/100ps
module rtcirq_top #(
  parameter int RAM_DEPTH = 114
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic [9:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // device pins and status
  input wire logic reset_n_i,
  input wire logic power_fail_trip_i,
  input wire logic ram_wipe_n_i,
  input wire logic bus_mode_i,
  input wire logic ext_osc_i,
  input wire rtcirq_pkg::rtcirq_evt_t evt_i,
  output logic irq_n_o,
  output logic irq_oe_o,
  output logic square_wave_out_o,
  output logic osc_enable_o,
  output logic hour24_mode_o,
  output logic clock_set_o
);
  import rtcirq_pkg::*;

  // control and status state
  logic [7:0] ctrl_a;
  logic [7:0] ctrl_b;
  logic periodic_flag;
  logic alarm_flag;
  logic update_flag;
  logic ack;
  logic [31:0] rdata;
  logic [7:0] next_ctrl_a;
  logic [7:0] next_ctrl_b;
  logic next_periodic_flag;
  logic next_alarm_flag;
  logic next_update_flag;
  logic next_ack;
  logic [31:0] next_rdata;
  // timebase and divider chain
  logic [15:0] tick_cnt;
  logic [DIV_STAGES-1:0] divider;
  logic [15:0] next_tick_cnt;
  logic [DIV_STAGES-1:0] next_divider;
  logic sq_wave;
  logic next_sq_wave;
  // ram wipe sequencer
  typedef enum logic [1:0]
  {
    WIPE_IDLE = 2'b00,
    WIPE_RUN = 2'b01,
    WIPE_HOLD = 2'b10
  } rtcirq_wipe_t;
  rtcirq_wipe_t wipe_state;
  rtcirq_wipe_t next_wipe_state;
  logic [6:0] wipe_addr;
  logic [6:0] next_wipe_addr;

  logic access_ok;
  logic bus_req;
  logic ram_hit;
  logic [6:0] ram_idx;
  logic ram_we;
  logic [6:0] ram_waddr;
  logic [7:0] ram_wdata;
  logic [7:0] ram_rdata;
  logic ram_rd_wait;
  logic next_ram_rd_wait;
  logic summary_int_flag;
  logic [7:0] status_c;
  logic [7:0] addr;
  logic osc_on;
  logic tb_tick;
  logic tap;
  logic [3:0] rate;

  assign addr = adr_i[7:0];
  // host access needs supply good and reset input high
  assign access_ok = !power_fail_trip_i && reset_n_i;
  // classic wishbone; the selected strobe convention is resolved ahead of this port
  assign bus_req = cyc_i && stb_i && access_ok && (adr_i[9:8] == 2'b00);
  assign ram_idx = 7'(addr - REG_RAM_BASE) >> 0;
  assign ram_hit = (addr >= REG_RAM_BASE) && (ram_idx < 7'(RAM_BYTES));
  assign osc_on = (ctrl_a[OSC_LSB +: OSC_W] == OSC_RUN);
  assign rate = ctrl_a[RATE_LSB +: RATE_W];

  // summary flag and open-drain request
  assign summary_int_flag = (periodic_flag && ctrl_b[B_PERIODIC_EN]) || (alarm_flag && ctrl_b[B_ALARM_EN])
    || (update_flag && ctrl_b[B_UPDATE_EN]);
  assign status_c = {summary_int_flag, periodic_flag, alarm_flag, update_flag, 4'h0};
  assign irq_oe_o = summary_int_flag;
  assign irq_n_o = 1'b0;

  assign square_wave_out_o = sq_wave;
  assign osc_enable_o = osc_on;
  assign hour24_mode_o = ctrl_b[B_H24];
  assign clock_set_o = ctrl_b[B_SET];
  assign ack_o = ack;
  assign dat_o = rdata;

  // tap selection: rates 1..2 reuse stages 6..7 (the taps of rates 8..9), 3..15 are the 13 taps
  always_comb
  begin
    tap = 1'b0;
    case (rate)
      4'h0: tap = 1'b0;
      4'h1: tap = divider[6];
      4'h2: tap = divider[7];
      default: tap = divider[4'(rate) - 4'h2];
    endcase
  end

  // timebase tick and divider
  always_comb
  begin
    next_tick_cnt = tick_cnt;
    next_divider = divider;
    tb_tick = 1'b0;
    if (osc_on)
    begin
      if (ext_osc_i || (tick_cnt == 16'(TICK_CYCLES - 1)))
      begin
        tb_tick = 1'b1;
      end
      next_tick_cnt = tb_tick ? 16'h0000 : tick_cnt + 16'h0001;
      if (tb_tick)
      begin
        next_divider = divider + 15'h0001;
      end
    end
    next_sq_wave = 1'b0;
    if (ctrl_b[B_SQUARE_EN] && !power_fail_trip_i && osc_on)
    begin
      next_sq_wave = tap;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tick_cnt <= 16'h0000;
      divider <= '0;
      sq_wave <= 1'b0;
    end
    else
    begin
      tick_cnt <= next_tick_cnt;
      divider <= next_divider;
      sq_wave <= next_sq_wave;
    end
  end

  // registers, flags and bus answer
  always_comb
  begin
    next_ctrl_a = ctrl_a;
    next_ctrl_b = ctrl_b;
    next_periodic_flag = periodic_flag;
    next_alarm_flag = alarm_flag;
    next_update_flag = update_flag;
    next_ack = 1'b0;
    next_rdata = rdata;
    next_ram_rd_wait = 1'b0;
    if (bus_req && !ack && ram_hit && !we_i && !ram_rd_wait)
    begin
      next_ram_rd_wait = 1'b1;
    end
    else if (bus_req && !ack)
    begin
      next_ack = 1'b1;
      next_rdata = 32'h0000_0000;
      if (we_i && sel_i[0])
      begin
        case (addr)
          REG_CTRL_A: next_ctrl_a = dat_i[7:0];
          REG_CTRL_B: next_ctrl_b = dat_i[7:0];
          default: next_ctrl_a = ctrl_a;
        endcase
      end
      else if (!we_i)
      begin
        case (addr)
          REG_CTRL_A: next_rdata[7:0] = ctrl_a;
          REG_CTRL_B: next_rdata[7:0] = ctrl_b;
          REG_STATUS_C:
          begin
            next_rdata[7:0] = status_c;
            next_periodic_flag = 1'b0;
            next_alarm_flag = 1'b0;
            next_update_flag = 1'b0;
          end
          REG_SUPPLY_D: next_rdata[D_VRT] = !power_fail_trip_i;
          REG_EVENTS: next_rdata[7:0] = 8'(CLK_BYTES);
          default: next_rdata = 32'h0000_0000;
        endcase
      end
    end
    // hardware events win over the clearing read
    if (evt_i.periodic)
    begin
      next_periodic_flag = 1'b1;
    end
    if (evt_i.alarm)
    begin
      next_alarm_flag = 1'b1;
    end
    if (evt_i.update_end)
    begin
      next_update_flag = 1'b1;
    end
    if (!reset_n_i && !power_fail_trip_i)
    begin
      next_ctrl_b[B_PERIODIC_EN] = 1'b0;
      next_ctrl_b[B_ALARM_EN] = 1'b0;
      next_ctrl_b[B_UPDATE_EN] = 1'b0;
      next_ctrl_b[B_SQUARE_EN] = 1'b0;
      next_periodic_flag = 1'b0;
      next_alarm_flag = 1'b0;
      next_update_flag = 1'b0;
    end
    if (ram_hit && bus_req && !we_i && !ack && ram_rd_wait)
    begin
      next_rdata = {24'h00_0000, ram_rdata};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_a <= CTRL_A_RST;
      ctrl_b <= CTRL_B_RST;
      periodic_flag <= 1'b0;
      alarm_flag <= 1'b0;
      update_flag <= 1'b0;
      ack <= 1'b0;
      ram_rd_wait <= 1'b0;
      rdata <= 32'h0000_0000;
    end
    else
    begin
      ctrl_a <= next_ctrl_a;
      ctrl_b <= next_ctrl_b;
      periodic_flag <= next_periodic_flag;
      alarm_flag <= next_alarm_flag;
      update_flag <= next_update_flag;
      ack <= next_ack;
      ram_rd_wait <= next_ram_rd_wait;
      rdata <= next_rdata;
    end
  end

  // ram wipe: only on battery with the wipe input held low
  always_comb
  begin
    next_wipe_state = wipe_state;
    next_wipe_addr = wipe_addr;
    case (wipe_state)
      WIPE_IDLE:
      begin
        if (power_fail_trip_i && !ram_wipe_n_i)
        begin
          next_wipe_state = WIPE_RUN;
          next_wipe_addr = 7'h00;
        end
      end
      WIPE_RUN:
      begin
        if (!power_fail_trip_i || ram_wipe_n_i)
        begin
          next_wipe_state = WIPE_IDLE;
        end
        else if (wipe_addr == 7'(RAM_DEPTH - 1))
        begin
          next_wipe_state = WIPE_HOLD;
        end
        else
        begin
          next_wipe_addr = wipe_addr + 7'h01;
        end
      end
      WIPE_HOLD:
      begin
        if (ram_wipe_n_i || !power_fail_trip_i)
        begin
          next_wipe_state = WIPE_IDLE;
        end
      end
      default: next_wipe_state = WIPE_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wipe_state <= WIPE_IDLE;
      wipe_addr <= 7'h00;
    end
    else
    begin
      wipe_state <= next_wipe_state;
      wipe_addr <= next_wipe_addr;
    end
  end

  // wipe touches only general ram, never control bytes
  always_comb
  begin
    ram_we = 1'b0;
    ram_waddr = ram_idx;
    ram_wdata = dat_i[7:0];
    if (wipe_state == WIPE_RUN)
    begin
      ram_we = 1'b1;
      ram_waddr = wipe_addr;
      ram_wdata = RAM_WIPE_VAL;
    end
    else if (bus_req && we_i && sel_i[0] && ram_hit && !ack)
    begin
      ram_we = 1'b1;
    end
  end

  rtcirq_ram #(
    .DEPTH(RAM_DEPTH),
    .AW(7)
  ) u_ram (
    .clk_i(clk_i),
    .we_i(ram_we),
    .waddr_i(ram_waddr),
    .wdata_i(ram_wdata),
    .raddr_i(ram_idx),
    .rdata_o(ram_rdata)
  );
endmodule

/* include/rtcirq_pkg.sv */
// package for the rtc interrupt, square-wave and ram-clear block
package rtcirq_pkg;
  // wishbone word offsets (byte address)
  localparam logic [7:0] REG_CTRL_A = 8'h00;
  localparam logic [7:0] REG_CTRL_B = 8'h04;
  localparam logic [7:0] REG_STATUS_C = 8'h08;
  localparam logic [7:0] REG_SUPPLY_D = 8'h0c;
  localparam logic [7:0] REG_EVENTS = 8'h10;
  localparam logic [7:0] REG_RAM_BASE = 8'h80;
  // control a fields
  localparam int RATE_LSB = 0;
  localparam int RATE_W = 4;
  localparam int OSC_LSB = 4;
  localparam int OSC_W = 3;
  localparam logic [2:0] OSC_RUN = 3'h2;
  // control b fields
  localparam int B_SET = 7;
  localparam int B_PERIODIC_EN = 6;
  localparam int B_ALARM_EN = 5;
  localparam int B_UPDATE_EN = 4;
  localparam int B_SQUARE_EN = 3;
  localparam int B_DM = 2;
  localparam int B_H24 = 1;
  localparam int B_DSE = 0;
  // status c and supply d fields
  localparam int C_SUMMARY = 7;
  localparam int C_PERIODIC = 6;
  localparam int C_ALARM = 5;
  localparam int C_UF = 4;
  localparam int D_VRT = 7;
  // organisation
  localparam int CLK_BYTES = 14;
  localparam int RAM_BYTES = 114;
  localparam int DIV_STAGES = 15;
  localparam int NUM_TAPS = 13;
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] RAM_WIPE_VAL = 8'hff;
  // timebase: 32.768 kHz tick from 50 MHz system clock
  localparam int TIMEBASE_HZ = 32768;
  localparam int SYS_HZ = 50000000;
  localparam int TICK_CYCLES = SYS_HZ / TIMEBASE_HZ;

  typedef struct packed
  {
    logic [7:0] adr;
    logic [7:0] dat;
    logic we;
    logic sel;
    logic req;
  } rtcirq_wb_req_t;

  typedef struct packed
  {
    logic periodic;
    logic alarm;
    logic update_end;
  } rtcirq_evt_t;
endpackage

/* hw/rtcirq_ram.sv */
// general-purpose ram with registered read and one write port shared by bus and wipe
`timescale 1ns/100ps
module rtcirq_ram #(
  parameter int DEPTH = 114,
  parameter int AW = 7
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [DEPTH];
  logic [7:0] next_rdata;

  always_comb
  begin
    next_rdata = mem[raddr_i];
  end

  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= next_rdata;
  end
endmodule

/* dv/rtcirq_monitor.sv */
// port assertions for the rtc interrupt block
`timescale 1ns/100ps
module rtcirq_chk
  import rtcirq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic ack_o,
  input wire logic reset_n_i,
  input wire logic power_fail_trip_i,
  input wire rtcirq_pkg::rtcirq_evt_t evt_i,
  input wire logic irq_n_o,
  input wire logic irq_oe_o,
  input wire logic square_wave_out_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  chk_irq_open_drain: assert property (irq_n_o == 1'b0)
    else $error("irq data not low");
  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  chk_ack_answer: assert property (cyc_i && stb_i && reset_n_i && !power_fail_trip_i && adr_i[9:8] == 2'b00
    && !ack_o && !(!we_i && adr_i[7:0] >= REG_RAM_BASE && adr_i[7:0] < 8'(REG_RAM_BASE + RAM_BYTES)) |=> ack_o)
    else $error("no ack");
  chk_ram_read_wait: assert property (cyc_i && stb_i && reset_n_i && !power_fail_trip_i && adr_i[9:8] == 2'b00
    && !we_i && adr_i[7:0] >= REG_RAM_BASE && adr_i[7:0] < 8'(REG_RAM_BASE + RAM_BYTES) && !$past(stb_i)
    |=> !ack_o ##1 ack_o)
    else $error("ram read not answered after one wait cycle");
  chk_ack_reset_n: assert property (!reset_n_i |=> !ack_o)
    else $error("ack in reset");
  chk_ack_pfail: assert property (power_fail_trip_i |=> !ack_o)
    else $error("ack in power fail");
  chk_square_pfail: assert property (power_fail_trip_i [*2] |-> !square_wave_out_o)
    else $error("square wave in power fail");
  chk_irq_reset_n: assert property (!reset_n_i && !power_fail_trip_i |=> !irq_oe_o)
    else $error("irq kept in reset");
  chk_irq_read_clr: assert property (evt_i == 3'b000 ##1 (evt_i == 3'b000 && ack_o && !we_i
    && adr_i == {2'b00, REG_STATUS_C}) |=> !irq_oe_o)
    else $error("irq kept after status read");
endmodule
bind rtcirq_top rtcirq_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .ack_o(ack_o), .reset_n_i(reset_n_i), .power_fail_trip_i(power_fail_trip_i), .evt_i(evt_i),
  .irq_n_o(irq_n_o), .irq_oe_o(irq_oe_o), .square_wave_out_o(square_wave_out_o));

/* dv/rtcirq_host.sv */
// wishbone host model for the register bus
`timescale 1ns/100ps
module rtcirq_host
  import rtcirq_pkg::*;
(
  input wire logic clk_i,
  input wire rtcirq_pkg::rtcirq_wb_req_t req_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output rtcirq_pkg::rtcirq_wb_req_t bus_o,
  output logic [7:0] rdata_o,
  output logic done_o
);
  initial
  begin
    bus_o = '0;
    rdata_o = 8'h00;
    done_o = 1'b0;
  end
  always @(posedge clk_i)
  begin
    done_o <= 1'b0;
    if (bus_o.req && ack_i)
    begin
      bus_o.req <= 1'b0;
      rdata_o <= dat_i[7:0];
      done_o <= 1'b1;
    end
    else if (bus_o.req && !req_i.req)
      bus_o.req <= 1'b0;
    else if (!bus_o.req && !done_o && req_i.req)
      bus_o <= req_i;
  end
endmodule

/* dv/tb.sv */
// self-checking bench for the rtc interrupt block
`timescale 1ns/100ps
module tb;
  import rtcirq_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic reset_n_i = 1'b1;
  logic pwr_fail = 1'b0;
  logic wipe_n = 1'b1;
  rtcirq_evt_t evt = '0;
  rtcirq_wb_req_t req = '0;
  rtcirq_wb_req_t bus;
  logic [31:0] rdat;
  logic [7:0] rd;
  logic [7:0] d;
  logic ack, done, irq_n, irq_oe, sq, osc_en, h24, cset;
  int err_count = 0;
  int checks_done = 0;
  int seed = 32'hab7b_600c;
  int n;
  int rates[7] = '{0, 1, 3, 4, 5, 6, 15};
  always #10 clk_i = ~clk_i;
  rtcirq_host host (.clk_i(clk_i), .req_i(req), .ack_i(ack), .dat_i(rdat), .bus_o(bus), .rdata_o(rd),
    .done_o(done));
  rtcirq_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(bus.req), .stb_i(bus.req), .we_i(bus.we),
    .sel_i({4{bus.sel}}), .adr_i({2'b00, bus.adr}), .dat_i({24'h00_0000, bus.dat}), .dat_o(rdat), .ack_o(ack),
    .reset_n_i(reset_n_i), .power_fail_trip_i(pwr_fail), .ram_wipe_n_i(wipe_n), .bus_mode_i(1'b0),
    .ext_osc_i(1'b1), .evt_i(evt), .irq_n_o(irq_n), .irq_oe_o(irq_oe), .square_wave_out_o(sq),
    .osc_enable_o(osc_en), .hour24_mode_o(h24), .clock_set_o(cset));
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(string w, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic xfer(logic w, logic [7:0] a, logic [7:0] dt, logic ea);
    int k;
    k = 0;
    req <= '{adr: a, dat: dt, we: w, sel: 1'b1, req: 1'b1};
    @(posedge clk_i);
    while (done !== 1'b1 && k < 20)
    begin
      @(posedge clk_i);
      k++;
    end
    chk("ack", {7'h00, ea}, {7'h00, done === 1'b1});
    req.req <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rdc(string w, logic [7:0] a, logic [7:0] e);
    xfer(1'b0, a, 8'h00, 1'b1);
    chk(w, e, rd);
  endtask
  task automatic pulse(logic [2:0] e);
    evt <= e;
    @(posedge clk_i);
    evt <= '0;
    @(posedge clk_i);
  endtask
  task automatic toggles(output int t);
    logic p;
    t = 0;
    repeat (128)
    begin
      p = sq;
      @(posedge clk_i);
      t += int'(sq !== p);
    end
  endtask
  function automatic int exp_tog(int r);
    return (r == 0) ? 0 : 128 >> ((r < 3) ? r + 5 : r - 2);
  endfunction
  initial
  begin
    #(20 * 20000);
    err_count++;
    summarize();
  end
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc("ctrl_a", REG_CTRL_A, CTRL_A_RST);
    rdc("ctrl_b", REG_CTRL_B, CTRL_B_RST);
    rdc("clk_bytes", REG_EVENTS, 8'(CLK_BYTES));
    rdc("supply", REG_SUPPLY_D, 8'h80);
    rdc("unmapped", 8'h20, 8'h00);
    xfer(1'b1, REG_CTRL_A, {1'b0, OSC_RUN, 4'h0}, 1'b1);
    xfer(1'b1, REG_CTRL_B, 8'h82, 1'b1);
    chk("osc_en", 8'h01, {7'h00, osc_en});
    chk("h24", 8'h01, {7'h00, h24});
    chk("clock_set", 8'h01, {7'h00, cset});
    $display("test regs done");
    for (int i = 0; i < 3; i++)
    begin
      xfer(1'b1, REG_CTRL_B, 8'h40 >> i, 1'b1);
      pulse(3'b100 >> i);
      chk("irq_oe", 8'h01, {7'h00, irq_oe});
      rdc("status", REG_STATUS_C, 8'h80 | (8'h40 >> i));
      chk("irq_clr", 8'h00, {7'h00, irq_oe});
      pulse(3'b100 >> ((i + 1) % 3));
      chk("irq_mask", 8'h00, {7'h00, irq_oe});
      rdc("status_mask", REG_STATUS_C, 8'h40 >> ((i + 1) % 3));
    end
    xfer(1'b1, REG_STATUS_C, 8'hff, 1'b1);
    rdc("status_ro", REG_STATUS_C, 8'h00);
    xfer(1'b1, REG_SUPPLY_D, 8'h00, 1'b1);
    rdc("supply_ro", REG_SUPPLY_D, 8'h80);
    xfer(1'b1, REG_CTRL_B, 8'h78, 1'b1);
    pulse(3'b111);
    reset_n_i <= 1'b0;
    xfer(1'b0, REG_CTRL_B, 8'h00, 1'b0);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    chk("irq_rst", 8'h00, {7'h00, irq_oe});
    rdc("ctrl_b_rst", REG_CTRL_B, 8'h00);
    rdc("status_rst", REG_STATUS_C, 8'h00);
    $display("test irq done");
    xfer(1'b1, REG_CTRL_B, 8'h08, 1'b1);
    foreach (rates[j])
    begin
      xfer(1'b1, REG_CTRL_A, {1'b0, OSC_RUN, 4'(rates[j])}, 1'b1);
      toggles(n);
      chk("sq_rate", 8'h01, {7'h00, n >= exp_tog(rates[j]) - 1 && n <= exp_tog(rates[j]) + 1});
    end
    xfer(1'b1, REG_CTRL_A, {1'b0, OSC_RUN, 4'h3}, 1'b1);
    xfer(1'b1, REG_CTRL_B, 8'h00, 1'b1);
    toggles(n);
    chk("sq_off_edges", 8'h00, 8'(n));
    chk("sq_off_level", 8'h00, {7'h00, sq});
    xfer(1'b1, REG_CTRL_B, 8'h08, 1'b1);
    pwr_fail <= 1'b1;
    xfer(1'b0, REG_CTRL_A, 8'h00, 1'b0);
    toggles(n);
    chk("sq_pf_edges", 8'h00, 8'(n));
    chk("sq_pf_level", 8'h00, {7'h00, sq});
    pwr_fail <= 1'b0;
    $display("test square wave done");
    d = 8'($random(seed));
    xfer(1'b1, REG_RAM_BASE, d, 1'b1);
    xfer(1'b1, 8'hf1, ~d, 1'b1);
    wipe_n <= 1'b0;
    repeat (130) @(posedge clk_i);
    rdc("ram_no_wipe", REG_RAM_BASE, d);
    pwr_fail <= 1'b1;
    repeat (130) @(posedge clk_i);
    wipe_n <= 1'b1;
    pwr_fail <= 1'b0;
    @(posedge clk_i);
    rdc("ram_first", REG_RAM_BASE, RAM_WIPE_VAL);
    rdc("ram_last", 8'hf1, RAM_WIPE_VAL);
    rdc("ctrl_kept", REG_CTRL_A, {1'b0, OSC_RUN, 4'h3});
    $display("test ram wipe done");
    summarize();
  end
endmodule
